// file: logic/afc_regs.svh
// Register offsets, write masks, field positions, reset values and the read-back bit count of the front-end control block.
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH
`define AFC_ADDR_SETUP1    6'h01
`define AFC_ADDR_SETUP2    6'h02
`define AFC_ADDR_SETUP3    6'h03
`define AFC_ADDR_SWRESET   6'h04
`define AFC_ADDR_ACYCRST   6'h05
`define AFC_ADDR_SETUP4    6'h06
`define AFC_ADDR_REVISION  6'h07
`define AFC_ADDR_SETUP5    6'h08
`define AFC_ADDR_SETUP6    6'h09
`define AFC_ADDR_SPECIAL   6'h0C
`define AFC_ADDR_LAST      6'h0C
`define AFC_ADDR_RB_BIT    4
`define AFC_DEF_SETUP1     8'h03
`define AFC_DEF_SETUP2     8'h20
`define AFC_DEF_SETUP3     8'h1F
`define AFC_MASK_SETUP2    8'hEF
`define AFC_MASK_SETUP5    8'h1F
`define AFC_MASK_SETUP6    8'h0F
`define AFC_MASK_SPECIAL   8'h02
`define AFC_BIT_EN         0
`define AFC_BIT_SINGLE_CHANNEL_MODE       2
`define AFC_BIT_SELECTIVE_POWERDOWN      3
`define AFC_BIT_LBL        0
`define AFC_BIT_ACYC       1
`define AFC_BIT_FME        2
`define AFC_BIT_DET        0
`define AFC_BIT_POL        4
`define AFC_SO_BITS        3'h7
`endif

// file: logic/afc_pkg.sv
// Types shared by the front-end control block.
package afc_pkg;
	typedef enum logic [1:0] {
		AFC_SO_IDLE  = 2'h0,
		AFC_SO_SHIFT = 2'h1
	} afc_so_state_t;
	typedef enum logic [1:0] {
		AFC_RED   = 2'h0,
		AFC_GREEN = 2'h1,
		AFC_BLUE  = 2'h2
	} afc_colour_t;
endpackage

// file: logic/afc_control.sv
// Control, serial port, sync detection, power and colour selection of the front end.
`timescale 1ns/10ps
`include "afc_regs.svh"
module afc_control
	import afc_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h5A // Arbitrary value.
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_clk_en,
	input  wire logic       i_serial_clock_pin,
	input  wire logic       i_serial_data_in,
	input  wire logic       i_serial_load_strobe,
	input  wire logic       i_pixel_sync,
	input  wire logic       i_autocycle_pulse_pin,
	input  wire logic [5:0] i_addr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_wr_stb,
	input  wire logic       i_rd_stb,
	output logic      [7:0] o_rd_data,
	output logic            o_serial_data_out,
	output logic            o_serial_data_oe,
	output logic            o_sample_strobe,
	output logic            o_powerdown_all,
	output logic      [3:0] o_block_disable,
	output logic            o_green_pd,
	output logic            o_blue_pd,
	output logic            o_single_channel,
	output logic      [1:0] o_input_mux_sel,
	output logic      [1:0] o_offset_gain_sel
);

	// Reset value of a register slot.
	function automatic logic [7:0] reg_default(input logic [5:0] a);
		case (a)
			`AFC_ADDR_SETUP1: reg_default = `AFC_DEF_SETUP1;
			`AFC_ADDR_SETUP2: reg_default = `AFC_DEF_SETUP2;
			`AFC_ADDR_SETUP3: reg_default = `AFC_DEF_SETUP3;
			default:          reg_default = 8'h00;
		endcase
	endfunction

	// Writable bits of a register slot; zero for write-only or absent slots.
	function automatic logic [7:0] wr_mask(input logic [5:0] a);
		case (a)
			`AFC_ADDR_SETUP1, `AFC_ADDR_SETUP3, `AFC_ADDR_SETUP4: wr_mask = 8'hFF;
			`AFC_ADDR_SETUP2:  wr_mask = `AFC_MASK_SETUP2;
			`AFC_ADDR_SETUP5:  wr_mask = `AFC_MASK_SETUP5;
			`AFC_ADDR_SETUP6:  wr_mask = `AFC_MASK_SETUP6;
			`AFC_ADDR_SPECIAL: wr_mask = `AFC_MASK_SPECIAL;
			default:           wr_mask = 8'h00;
		endcase
	endfunction

	// Register storage, indexed by address.
	logic [7:0] regs_reg [0:12];

	// Read value of an address; unmapped and write-only slots read zero.
	function automatic logic [7:0] read_reg(input logic [5:0] a);
		if (a == `AFC_ADDR_REVISION) begin
			read_reg = REVISION;
		end else if (a <= `AFC_ADDR_LAST) begin
			read_reg = regs_reg[a[3:0]] & wr_mask(a);
		end else begin
			read_reg = 8'h00;
		end
	endfunction

	// Two-flop synchronisers for every pin input.
	// The serial clock rests high, so its flops reset high and no false edge follows reset.
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic [1:0] sen_sync_reg;
	logic [1:0] psync_sync_reg;
	logic [1:0] acyc_sync_reg;
	logic       sclk_prev_reg;
	logic       sen_prev_reg;
	logic       psync_prev_reg;
	logic       acyc_prev_reg;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sclk_sync_reg  <= 2'h3;
			sdi_sync_reg   <= 2'h0;
			sen_sync_reg   <= 2'h0;
			psync_sync_reg <= 2'h0;
			acyc_sync_reg  <= 2'h0;
			sclk_prev_reg  <= 1'b1;
			sen_prev_reg   <= 1'b0;
			psync_prev_reg <= 1'b0;
			acyc_prev_reg  <= 1'b0;
		end else if (i_clk_en) begin
			sclk_sync_reg  <= {sclk_sync_reg[0], i_serial_clock_pin};
			sdi_sync_reg   <= {sdi_sync_reg[0], i_serial_data_in};
			sen_sync_reg   <= {sen_sync_reg[0], i_serial_load_strobe};
			psync_sync_reg <= {psync_sync_reg[0], i_pixel_sync};
			acyc_sync_reg  <= {acyc_sync_reg[0], i_autocycle_pulse_pin};
			sclk_prev_reg  <= sclk_sync_reg[1];
			sen_prev_reg   <= sen_sync_reg[1];
			psync_prev_reg <= psync_sync_reg[1];
			acyc_prev_reg  <= acyc_sync_reg[1];
		end
	end

	// Edges of the synchronised pins.
	wire sclk_rise  = sclk_sync_reg[1] & ~sclk_prev_reg;
	wire sclk_fall  = ~sclk_sync_reg[1] & sclk_prev_reg;
	wire sen_rise   = sen_sync_reg[1] & ~sen_prev_reg;
	wire psync_rise = psync_sync_reg[1] & ~psync_prev_reg;
	wire psync_fall = ~psync_sync_reg[1] & psync_prev_reg;
	wire acyc_rise  = acyc_sync_reg[1] & ~acyc_prev_reg;

	// Serial input shifter: address then data, MSB first, on rising serial clock.
	// Only the last fourteen bits before the load strobe count; older bits fall off the top.
	logic [13:0] shift_in_reg;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			shift_in_reg <= 14'h0000;
		end else if (i_clk_en && sclk_rise) begin
			shift_in_reg <= {shift_in_reg[12:0], sdi_sync_reg[1]};
		end
	end

	// Decoding of the loaded serial word and of the parallel port.
	wire [5:0] ser_addr  = shift_in_reg[13:8];
	wire [7:0] ser_data  = shift_in_reg[7:0];
	wire       ser_rd    = sen_rise & ser_addr[`AFC_ADDR_RB_BIT];
	wire       ser_wr    = sen_rise & ~ser_addr[`AFC_ADDR_RB_BIT];
	wire [5:0] rb_addr   = {ser_addr[5], 1'b0, ser_addr[3:0]};
	wire [7:0] rb_word   = read_reg(rb_addr);
	wire       sw_reset  = (ser_wr && ser_addr == `AFC_ADDR_SWRESET) ||
	                       (i_wr_stb && i_addr == `AFC_ADDR_SWRESET);
	wire       acyc_rst  = (ser_wr && ser_addr == `AFC_ADDR_ACYCRST) ||
	                       (i_wr_stb && i_addr == `AFC_ADDR_ACYCRST);

	// Register file; serial loads are taken in the core domain after synchronising.
	// A serial load beats a parallel write to the same slot in the same cycle.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i <= 12; i++) begin
				regs_reg[i] <= reg_default(6'(i));
			end
		end else if (i_clk_en) begin
			if (sw_reset) begin
				for (int i = 0; i <= 12; i++) begin
					regs_reg[i] <= reg_default(6'(i));
				end
			end else begin
				for (int i = 0; i <= 12; i++) begin
					if (i_wr_stb && i_addr == 6'(i)) begin
						regs_reg[i] <= i_wr_data & wr_mask(6'(i));
					end
					if (ser_wr && ser_addr == 6'(i)) begin
						regs_reg[i] <= ser_data & wr_mask(6'(i));
					end
				end
			end
		end
	end

	// Parallel read port: data stand in the cycle after the strobe only.
	// Zero outside that cycle keeps a stale word from looking valid.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rd_data <= 8'h00;
		end else if (i_clk_en) begin
			o_rd_data <= i_rd_stb ? read_reg(i_addr) : 8'h00;
		end
	end

	// Read-back shifter: MSB presented at load, next bit on each falling serial clock.
	// A new read-back strobe restarts the word; the fall after the last bit frees the pin.
	afc_so_state_t so_state_reg;
	logic [7:0]    so_bits_reg;
	logic [2:0]    so_cnt_reg;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			so_state_reg      <= AFC_SO_IDLE;
			so_bits_reg       <= 8'h00;
			so_cnt_reg        <= 3'h0;
			o_serial_data_out <= 1'b0;
			o_serial_data_oe  <= 1'b0;
		end else if (i_clk_en) begin
			if (ser_rd) begin
				so_state_reg      <= AFC_SO_SHIFT;
				so_bits_reg       <= rb_word;
				so_cnt_reg        <= `AFC_SO_BITS;
				o_serial_data_out <= rb_word[7];
				o_serial_data_oe  <= 1'b1;
			end else begin
				case (so_state_reg)
					AFC_SO_IDLE: begin
						o_serial_data_oe <= 1'b0;
					end
					AFC_SO_SHIFT: begin
						if (sclk_fall) begin
							so_bits_reg       <= {so_bits_reg[6:0], 1'b0};
							o_serial_data_out <= so_bits_reg[6];
							so_cnt_reg        <= so_cnt_reg - 3'h1;
							if (so_cnt_reg == 3'h0) begin
								so_state_reg      <= AFC_SO_IDLE;
								o_serial_data_out <= 1'b0;
								o_serial_data_oe  <= 1'b0;
							end
						end
					end
					default: begin
						so_state_reg <= AFC_SO_IDLE;
					end
				endcase
			end
		end
	end

	// Fields that steer the sampling, power and colour logic.
	wire       det_en    = regs_reg[8][`AFC_BIT_DET];
	wire       det_pol   = regs_reg[8][`AFC_BIT_POL];
	wire [2:0] det_delay = regs_reg[8][3:1];
	wire       selective_powerdown     = regs_reg[1][`AFC_BIT_SELECTIVE_POWERDOWN];
	wire       pwr_en    = regs_reg[1][`AFC_BIT_EN];
	wire       single_channel_mode      = regs_reg[1][`AFC_BIT_SINGLE_CHANNEL_MODE];
	wire [3:0] dis_mask  = regs_reg[9][3:0];
	wire [1:0] chan_sel  = regs_reg[3][7:6];
	wire       line_seq  = regs_reg[6][`AFC_BIT_LBL];
	wire       acyc_sel  = regs_reg[6][`AFC_BIT_ACYC];
	wire       force_en  = regs_reg[6][`AFC_BIT_FME];
	wire [1:0] intm_sel  = regs_reg[6][5:4];
	wire [1:0] force_sel = regs_reg[6][7:6];

	// Edge detector and delay counter for the internal sync pulse.
	// A new edge during a delay restarts the count, so one pulse follows the last edge.
	logic [2:0] dly_cnt_reg;
	wire        det_edge  = det_pol ? psync_rise : psync_fall;
	wire        dly_done  = (dly_cnt_reg == 3'h1);
	wire        int_pulse = (det_edge && det_delay == 3'h0) || dly_done;
	wire        sync_evt  = det_en ? int_pulse : psync_fall;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			dly_cnt_reg <= 3'h0;
		end else if (i_clk_en) begin
			if (det_en && det_edge && det_delay != 3'h0) begin
				dly_cnt_reg <= det_delay;
			end else if (dly_cnt_reg != 3'h0) begin
				dly_cnt_reg <= dly_cnt_reg - 3'h1;
			end
		end
	end

	// Sample strobe on the first edge after the (internal or pin) sync pulse.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sample_strobe <= 1'b0;
		end else if (i_clk_en) begin
			o_sample_strobe <= sync_evt;
		end
	end

	// Auto-cycle colour counter.
	// A reset write wins over a pulse that lands in the same cycle.
	afc_colour_t cyc_colour_reg;
	wire         cyc_step = acyc_sel & acyc_rise;
	wire [1:0]   cyc_next = (cyc_colour_reg == AFC_BLUE) ? AFC_RED : cyc_colour_reg + 2'h1;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cyc_colour_reg <= AFC_RED;
		end else if (i_clk_en) begin
			if (acyc_rst || sw_reset) begin
				cyc_colour_reg <= AFC_RED;
			end else if (cyc_step) begin
				cyc_colour_reg <= afc_colour_t'(cyc_next);
			end
		end
	end

	// Multiplexer selection and power decode.
	wire [1:0] og_sel    = acyc_sel ? cyc_colour_reg : intm_sel;
	wire [1:0] lbl_in    = force_en ? force_sel : og_sel;
	wire [1:0] in_sel    = line_seq ? lbl_in : chan_sel;
	wire [3:0] blk_dis   = selective_powerdown ? dis_mask : {4{~pwr_en}};
	wire       pd_all    = ~selective_powerdown & ~pwr_en;

	// Registered control outputs; register contents never depend on power state.
	// Green and blue are also off when the whole device is down.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_powerdown_all   <= 1'b0;
			o_block_disable   <= 4'h0;
			o_green_pd        <= 1'b0;
			o_blue_pd         <= 1'b0;
			o_single_channel  <= 1'b0;
			o_input_mux_sel   <= 2'h0;
			o_offset_gain_sel <= 2'h0;
		end else if (i_clk_en) begin
			o_powerdown_all   <= pd_all;
			o_block_disable   <= blk_dis;
			o_green_pd        <= line_seq | pd_all;
			o_blue_pd         <= line_seq | pd_all;
			o_single_channel  <= single_channel_mode | line_seq;
			o_input_mux_sel   <= in_sel;
			o_offset_gain_sel <= og_sel;
		end
	end

	// All checks run on the core clock and rest while reset is held.
	default clocking afc_cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);

	// Read-back bit order and release of the pin.
	sdo_first_bit_a: assert property (i_clk_en && ser_rd |=>
		o_serial_data_out == $past(rb_word[7]) && o_serial_data_oe)
		else $error("read-back MSB wrong");
	sdo_next_bit_a: assert property (i_clk_en && !ser_rd && so_state_reg == AFC_SO_SHIFT &&
		sclk_fall && so_cnt_reg != 3'h0 |=> o_serial_data_out == $past(so_bits_reg[6]))
		else $error("read-back bit order wrong");
	sdo_idle_a: assert property (i_clk_en && !ser_rd && so_state_reg == AFC_SO_IDLE |=>
		!o_serial_data_oe)
		else $error("read-back pin not released");

	// Sampling instant with and without the edge detector.
	sample_pin_a: assert property (i_clk_en && !det_en && psync_fall |=>
		o_sample_strobe)
		else $error("pin sync sample missed");
	sample_nodly_a: assert property (i_clk_en && det_en && det_edge && det_delay == 3'h0 |=>
		o_sample_strobe)
		else $error("undelayed internal sync missed");
	sample_dly_a: assert property (i_clk_en && det_en && det_edge && det_delay == 3'h2
		##1 i_clk_en && !det_edge
		##1 i_clk_en |=> o_sample_strobe)
		else $error("delayed internal sync wrong");
	sample_det_a: assert property (i_clk_en && det_en && !det_edge && dly_cnt_reg != 3'h1 |=>
		!o_sample_strobe)
		else $error("pin sync leaked past detector");

	// Power decode.
	full_pd_a: assert property (i_clk_en && !selective_powerdown && !pwr_en |=>
		o_powerdown_all && o_block_disable == 4'hF)
		else $error("full power down wrong");
	full_pu_a: assert property (i_clk_en && !selective_powerdown && pwr_en |=>
		!o_powerdown_all && o_block_disable == 4'h0)
		else $error("full power up wrong");
	sel_pd_a: assert property (i_clk_en && selective_powerdown |=>
		!o_powerdown_all && o_block_disable == $past(dis_mask))
		else $error("selective disable wrong");
	line_seq_a: assert property (i_clk_en && line_seq |=>
		o_green_pd && o_blue_pd && o_single_channel)
		else $error("line mode channels wrong");

	// Colour selection, auto-cycling and the resets that return it to red.
	mux_internal_a: assert property (i_clk_en && line_seq && !force_en && !acyc_sel |=>
		o_input_mux_sel == $past(intm_sel) && o_offset_gain_sel == $past(intm_sel))
		else $error("internal colour select wrong");
	mux_force_a: assert property (i_clk_en && line_seq && force_en |=>
		o_input_mux_sel == $past(force_sel))
		else $error("forced input select wrong");
	cycle_rst_a: assert property (i_clk_en && acyc_rst ##1 i_clk_en && acyc_sel |=>
		o_offset_gain_sel == AFC_RED)
		else $error("auto-cycle reset missed");
	cycle_step_a: assert property (i_clk_en && cyc_step && !acyc_rst && !sw_reset |=>
		($past(cyc_colour_reg) == AFC_RED && cyc_colour_reg == AFC_GREEN) ||
		($past(cyc_colour_reg) == AFC_GREEN && cyc_colour_reg == AFC_BLUE) ||
		($past(cyc_colour_reg) == AFC_BLUE && cyc_colour_reg == AFC_RED))
		else $error("auto-cycle step wrong");
	soft_reset_a: assert property (i_clk_en && sw_reset |=>
		regs_reg[1] == `AFC_DEF_SETUP1 && regs_reg[3] == `AFC_DEF_SETUP3)
		else $error("soft reset missed");
	colour_reset_a: assert property (i_clk_en && sw_reset |=>
		cyc_colour_reg == AFC_RED)
		else $error("soft reset left colour");

endmodule // afc_control

// file: bench/afc_host_model.sv
// Host-side model of the serial control port that writes and reads back registers.
`timescale 1ns/10ps
module afc_host_model (
	output logic       o_sclk,
	output logic       o_sdi,
	output logic       o_sen,
	input  wire logic  i_sdo_pin
);
	logic [7:0] rb_bits;

	// The serial clock rests high between frames and the load strobe rests low.
	initial begin
		o_sclk = 1'b1;
		o_sdi = 1'b0;
		o_sen = 1'b0;
		rb_bits = 8'h00;
	end

	// Shifts one word at an 80 ns bit period and collects read-back bits on the way.
	// Output enable is taken as held high, so the shared pin shows the read-back bit.
	task automatic send(input logic [5:0] a, input logic [7:0] d);
		logic [13:0] w;
		w = {a, d};
		rb_bits[7] = i_sdo_pin;
		for (int i = 13; i >= 0; i--) begin
			o_sclk = 1'b0;
			o_sdi = w[i];
			#40;
			if (i >= 7) begin
				rb_bits[i - 7] = i_sdo_pin;
			end
			o_sclk = 1'b1;
			#40;
		end
		o_sdi = ~w[0];
		o_sen = 1'b1;
		#40;
		o_sen = 1'b0;
		#80;
	endtask
endmodule // afc_host_model

// file: bench/afc_control_tb.sv
// Self-checking testbench of the front-end control block.
`timescale 1ns/10ps
module afc_control_tb;
	import afc_pkg::*;
	localparam logic [7:0] REV = 8'h3C; // Arbitrary value.
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic       en = 1'b1;
	logic       sclk, serial_data_in, serial_load_strobe;
	logic       pix = 1'b0;
	logic       acyc = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdat = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdat;
	logic       serial_data_out, sdo_oe, smp, pd_all, g_pd, b_pd, single;
	logic [3:0] dis;
	logic [1:0] in_sel, og_sel;
	wire        sdo_pin = sdo_oe ? serial_data_out : 1'b1;
	int         n_fail = 0;
	int         tests_run = 0;
	int         first, cnt, lat;

	// Core clock of 100 MHz.
	always #5 clk = ~clk;

	afc_control #(.REVISION(REV)) dut (
		.i_core_clk(clk), .i_resetn(rstn), .i_clk_en(en),
		.i_serial_clock_pin(sclk), .i_serial_data_in(serial_data_in), .i_serial_load_strobe(serial_load_strobe),
		.i_pixel_sync(pix), .i_autocycle_pulse_pin(acyc), .i_addr(addr),
		.i_wr_data(wdat), .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdat),
		.o_serial_data_out(serial_data_out), .o_serial_data_oe(sdo_oe), .o_sample_strobe(smp),
		.o_powerdown_all(pd_all), .o_block_disable(dis), .o_green_pd(g_pd),
		.o_blue_pd(b_pd), .o_single_channel(single), .o_input_mux_sel(in_sel),
		.o_offset_gain_sel(og_sel)
	);

	afc_host_model host (.o_sclk(sclk), .o_sdi(serial_data_in), .o_sen(serial_load_strobe), .i_sdo_pin(sdo_pin));

	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Bus write and read; each is entered right after a rising edge.
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), {8'h00, rdat}, {8'h00, exp});
		@(posedge clk);
	endtask

	// Serial word through the host model, started off the clock edge.
	task automatic ser(input logic [5:0] a, input logic [7:0] d);
		#1;
		host.send(a, d);
		@(posedge clk);
	endtask

	// Checks power and colour outputs once they have settled.
	task automatic pins(input logic [12:0] e);
		repeat (4) @(posedge clk);
		#1;
		check("outputs", {3'h0, pd_all, dis, g_pd, b_pd, single, in_sel, og_sel}, {3'h0, e});
		@(posedge clk);
	endtask

	task automatic pulse_acyc();
		acyc <= 1'b1;
		repeat (3) @(posedge clk);
		acyc <= 1'b0;
		@(posedge clk);
	endtask

	// Raises sync for hi cycles and records the first strobe cycle and the strobe count.
	task automatic sync_run(input int hi, output int f, output int n);
		f = -1;
		n = 0;
		pix <= 1'b1;
		for (int c = 1; c <= 30; c++) begin
			@(posedge clk);
			if (c == hi) begin
				pix <= 1'b0;
			end
			#1;
			if (smp === 1'b1) begin
				if (f < 0) begin
					f = c;
				end
				n++;
			end
		end
		@(posedge clk);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog far beyond the expected run length.
	initial begin
		#300000;
		n_fail++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk_reg(6'h01, 8'h03);
		chk_reg(6'h02, 8'h20);
		chk_reg(6'h03, 8'h1F);
		chk_reg(6'h07, REV);
		chk_reg(6'h30, 8'h00);
		pins(13'h0000);
		wr_reg(6'h07, 8'h00);
		chk_reg(6'h07, REV);
		wr_reg(6'h02, 8'hFF);
		chk_reg(6'h02, 8'hEF);
		// A write while the clock enable is low must leave the register as it was.
		en <= 1'b0;
		wr_reg(6'h02, 8'h00);
		en <= 1'b1;
		chk_reg(6'h02, 8'hEF);
		// Serial write that powers the device down, then read-back overlapped by the next word.
		ser(6'h01, 8'hC6);
		chk_reg(6'h01, 8'hC6);
		ser(6'h11, 8'hA5);
		ser(6'h03, 8'h9C);
		check("read-back", {8'h00, host.rb_bits}, 16'h00C6);
		check("read-back enable", {15'h0, sdo_oe}, 16'h0000);
		chk_reg(6'h03, 8'h9C);
		pins({1'h1, 4'hF, 3'h7, 2'h2, 2'h0});
		ser(6'h04, 8'hFF);
		chk_reg(6'h01, 8'h03);
		chk_reg(6'h03, 8'h1F);
		pins(13'h0000);
		// Power control through the enable bit and the selective mask.
		wr_reg(6'h09, 8'hF5);
		chk_reg(6'h09, 8'h05);
		wr_reg(6'h01, 8'h0A);
		pins({1'h0, 4'h5, 3'h0, 2'h0, 2'h0});
		wr_reg(6'h01, 8'h09);
		pins({1'h0, 4'h5, 3'h0, 2'h0, 2'h0});
		wr_reg(6'h01, 8'h02);
		pins({1'h1, 4'hF, 3'h6, 2'h0, 2'h0});
		wr_reg(6'h01, 8'h03);
		pins(13'h0000);
		// Single-channel input chosen by the host between lines.
		for (int k = 0; k < 3; k++) begin
			wr_reg(6'h03, {k[1:0], 6'h1F});
			pins({11'h000, k[1:0]} << 2);
		end
		wr_reg(6'h03, 8'h1F);
		// Line-sequential colour selection in all four selection modes.
		wr_reg(6'h06, 8'h21);
		pins({1'h0, 4'h0, 3'h7, 2'h2, 2'h2});
		wr_reg(6'h06, 8'h65);
		pins({1'h0, 4'h0, 3'h7, 2'h1, 2'h2});
		wr_reg(6'h06, 8'h93);
		pins({1'h0, 4'h0, 3'h7, 2'h0, 2'h0});
		for (int k = 1; k <= 3; k++) begin
			pulse_acyc();
			pins({1'h0, 4'h0, 3'h7, 2'(k % 3), 2'(k % 3)});
		end
		wr_reg(6'h06, 8'h97);
		for (int k = 1; k <= 4; k++) begin
			pulse_acyc();
			pins({1'h0, 4'h0, 3'h7, 2'h2, 2'(k % 3)});
		end
		wr_reg(6'h06, 8'h93);
		pins({1'h0, 4'h0, 3'h7, 2'h1, 2'h1});
		wr_reg(6'h05, 8'h5A);
		pins({1'h0, 4'h0, 3'h7, 2'h0, 2'h0});
		wr_reg(6'h06, 8'h00);
		// Pixel sync: plain pulse, then detector on both edges and every delay.
		sync_run(1, first, cnt);
		lat = first - 1;
		check("sync latency", 16'(lat >= 2 && lat <= 5), 16'h0001);
		check("sync count", 16'(cnt), 16'h0001);
		for (int p = 0; p < 2; p++) begin
			for (int n = 0; n < 8; n++) begin
				wr_reg(6'h08, {3'h0, p[0], n[2:0], 1'h1});
				sync_run(10, first, cnt);
				check("sync delay", 16'(first), 16'(lat + n + (p ? 0 : 10)));
				check("sync count", 16'(cnt), 16'h0001);
			end
		end
		print_verdict();
	end
endmodule // afc_control_tb
